// ===== verilog/axis_drive_defines.svh
// constants for the axis pulse-drive block: register map, fields, timing
// assumes a 10 MHz i_mclk and a 32-bit APB slave port
// Functional notes
// - outputs defined within 6 clocks of reset
// - no bus access for 4 clocks after reset
// - drive-active rises within 2 clocks of command
// - drive-active falls 1 clock after last pulse
// - first fixed/continuous pulse within 4 clocks
// - plus, minus, step pulses are active high
// - phase flags 3 after rise, clear 1 after fall
// - direction valid 1 clock after drive-active, held
// - first step pulse 1 clock after direction
// - interpolation pulse within 4, drive within 2
// - direction valid around each interpolation pulse
// - start-after-hold pulse within 4 clocks
// - instant stop finishes current pulse, then none
// - filter delays stop input by time constant
// - decelerating stop finishes pulse, then decelerates; interpolation drives ignore it and run to their count
// - lead split pulse aligned, later delayed one clock
// - without lead, every split pulse delayed one clock
// - outputs change only on rising clock edge; o_pslverr is combinational from the bus inputs
`ifndef AXIS_DRIVE_DEFINES_SVH
`define AXIS_DRIVE_DEFINES_SVH

`define CLK_PERIOD_NS 100
`define RESET_GUARD_CYCLES 3'h4
`define ADDR_CTRL 8'h00
`define ADDR_COUNT 8'h04
`define ADDR_START_PER 8'h08
`define ADDR_DRIVE_PER 8'h0C
`define ADDR_ACCEL 8'h10
`define ADDR_CMD 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_REMAIN 8'h1C
`define CTRL_ONE_PULSE 0
`define CTRL_HOLD 1
`define CTRL_SPLIT_EN 2
`define CTRL_SPLIT_LEAD 3
`define CTRL_LIMIT_INSTANT 4
`define CTRL_FILTER_EN 5
`define CTRL_FILTER_SEL_LO 6
`define CTRL_RESET 8'h00
`define START_PER_RESET 16'h0064
`define DRIVE_PER_RESET 16'h0014
`define ACCEL_RESET 16'h0001
`define ST_INSTANT_SEEN 6
`define ST_DECEL_SEEN 7
`define FILT_TC0_NS 400
`define FILT_TC1_NS 1600
`define FILT_TC2_NS 6400
`define FILT_TC3_NS 25600
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== verilog/axis_drive_pkg.sv
// types shared by the axis pulse-drive block
// assumes nothing beyond the constants header
package axis_drive_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HELD = 3'b001,
		ST_START = 3'b010,
		ST_HIGH = 3'b011,
		ST_LOW = 3'b100,
		ST_DONE = 3'b101
	} drive_state_t;
	typedef enum logic [1:0] {
		PH_ACCEL = 2'b00,
		PH_CONST = 2'b01,
		PH_DECEL = 2'b10
	} phase_t;
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_FIXED_PLUS = 4'h1,
		CMD_FIXED_MINUS = 4'h2,
		CMD_CONT_PLUS = 4'h3,
		CMD_CONT_MINUS = 4'h4,
		CMD_INTERP_PLUS = 4'h5,
		CMD_INTERP_MINUS = 4'h6,
		CMD_START_HELD = 4'h7,
		CMD_INSTANT_STOP = 4'h8,
		CMD_DECEL_STOP = 4'h9
	} cmd_t;
endpackage

// ===== verilog/axis_input_filter.sv
// one stop-input conditioner: synchroniser, then optional settle filter
// assumes an asynchronous active-low pin and a limit held stable by software
`timescale 1ns/1ps
`default_nettype none
module axis_input_filter #(
	parameter int CNT_W = 9
) (
	input wire logic i_mclk,
	input wire logic i_chip_reset_low,
	input wire logic i_pin_n,
	input wire logic i_filter_en,
	input wire logic [CNT_W-1:0] i_limit,
	output logic o_active
);
	logic sync1_reg;
	logic sync2_reg;
	logic filt_reg;
	logic [CNT_W-1:0] cnt_reg;

	// pins are asynchronous; only sync2 is read below
	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= ~i_pin_n;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			filt_reg <= 1'b0;
			cnt_reg <= '0;
		end
		else if (sync2_reg == filt_reg)
			cnt_reg <= '0;
		else if (cnt_reg >= i_limit)
		begin
			filt_reg <= sync2_reg;
			cnt_reg <= '0;
		end
		else
			cnt_reg <= cnt_reg + 1'b1;
	end

	// bypass still costs the two sync stages
	assign o_active = i_filter_en ? filt_reg : sync2_reg;
endmodule // axis_input_filter
`default_nettype wire

// ===== verilog/axis_pulse_drive_timing.sv
// one motion axis: APB registers, drive sequencer, pulse, direction, split
// assumes an APB master on i_mclk and active-low stop pins from the machine
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "axis_drive_defines.svh"
module axis_pulse_drive_timing
	import axis_drive_pkg::*;
#(
	parameter int PER_W = 16,
	parameter int CNT_W = 24,
	parameter int FILT_W = 9
) (
	input wire logic i_mclk,
	input wire logic i_chip_reset_low,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_emergency_stop_in_n,
	input wire logic i_servo_alarm_in_n,
	input wire logic [1:0] i_limit_switch_in_n,
	input wire logic [2:0] i_decel_stop_in_n,
	output logic o_axis_drive_active,
	output logic o_plus_pulse_out,
	output logic o_minus_pulse_out,
	output logic o_step_pulse_out,
	output logic o_direction_out,
	output logic o_split_pulse_out,
	output logic o_accel_phase_flag,
	output logic o_const_speed_flag,
	output logic o_decel_phase_flag
);
	localparam int NIN = 7;
	localparam logic [FILT_W-1:0] TC0 = FILT_W'(`NS_TO_CYC(`FILT_TC0_NS));
	localparam logic [FILT_W-1:0] TC1 = FILT_W'(`NS_TO_CYC(`FILT_TC1_NS));
	localparam logic [FILT_W-1:0] TC2 = FILT_W'(`NS_TO_CYC(`FILT_TC2_NS));
	localparam logic [FILT_W-1:0] TC3 = FILT_W'(`NS_TO_CYC(`FILT_TC3_NS));

	logic [7:0] ctrl_reg;
	logic [CNT_W-1:0] count_reg;
	logic [PER_W-1:0] start_per_reg;
	logic [PER_W-1:0] drive_per_reg;
	logic [PER_W-1:0] accel_reg;
	logic [2:0] guard_reg;
	logic [31:0] prdata_reg;
	logic inst_seen_reg;
	logic decel_seen_reg;
	drive_state_t state_reg;
	phase_t phase_reg;
	logic [PER_W-1:0] per_reg;
	logic [PER_W-1:0] tcnt_reg;
	logic [CNT_W-1:0] remain_reg;
	logic [CNT_W-1:0] accel_cnt_reg;
	logic cont_reg;
	logic interp_reg;
	logic dir_cmd_reg;
	logic dir_reg;
	logic drive_reg;
	logic pulse_reg;
	logic plus_reg;
	logic minus_reg;
	logic step_reg;
	logic split_reg;
	logic first_reg;
	logic [1:0] age_reg;
	logic [2:0] flags_reg;
	logic inst_req_reg;
	logic decel_req_reg;

	logic access;
	logic wr;
	logic addr_ok;
	logic [3:0] wcmd;
	logic drive_cmd;
	logic start_cmd;
	logic inst_cmd;
	logic decel_cmd;
	logic [NIN-1:0] pins_n;
	logic [NIN-1:0] act;
	logic [FILT_W-1:0] tc_sel;
	logic inst_in;
	logic decel_in;
	logic [PER_W-1:0] hi_len;
	logic pulse_start;
	logic end_high;
	logic end_low;
	logic go_on;
	logic pulse_next;
	logic [PER_W:0] per_up;

	// bus side
	assign access = i_psel && i_penable && o_pready;
	assign wr = access && i_pwrite;
	assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr <= `ADDR_REMAIN);
	assign wcmd = (wr && i_paddr == `ADDR_CMD) ? i_pwdata[3:0] : CMD_NONE;
	assign drive_cmd = (wcmd >= CMD_FIXED_PLUS) && (wcmd <= CMD_INTERP_MINUS);
	assign start_cmd = (wcmd == CMD_START_HELD) && (state_reg == ST_HELD);
	assign inst_cmd = (wcmd == CMD_INSTANT_STOP);
	assign decel_cmd = (wcmd == CMD_DECEL_STOP);

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
			guard_reg <= `RESET_GUARD_CYCLES;
		else if (guard_reg != 3'h0)
			guard_reg <= guard_reg - 3'h1;
	end
	assign o_pready = (guard_reg == 3'h0);
	assign o_pslverr = access && !addr_ok;

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			ctrl_reg <= `CTRL_RESET;
			count_reg <= '0;
			start_per_reg <= `START_PER_RESET;
			drive_per_reg <= `DRIVE_PER_RESET;
			accel_reg <= `ACCEL_RESET;
		end
		else if (wr)
		begin
			unique case (i_paddr)
				`ADDR_CTRL: ctrl_reg <= i_pwdata[7:0];
				`ADDR_COUNT: count_reg <= i_pwdata[CNT_W-1:0];
				`ADDR_START_PER: start_per_reg <= i_pwdata[PER_W-1:0];
				`ADDR_DRIVE_PER: drive_per_reg <= i_pwdata[PER_W-1:0];
				`ADDR_ACCEL: accel_reg <= i_pwdata[PER_W-1:0];
				default: ;
			endcase
		end
	end

	// read data sampled every bus cycle, so it is one clock old
	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
			prdata_reg <= 32'h0;
		else if (i_psel)
		begin
			unique case (i_paddr)
				`ADDR_CTRL: prdata_reg <= {24'h0, ctrl_reg};
				`ADDR_COUNT: prdata_reg <= 32'(count_reg);
				`ADDR_START_PER: prdata_reg <= 32'(start_per_reg);
				`ADDR_DRIVE_PER: prdata_reg <= 32'(drive_per_reg);
				`ADDR_ACCEL: prdata_reg <= 32'(accel_reg);
				`ADDR_STATUS: prdata_reg <= {17'h0, act, decel_seen_reg, inst_seen_reg,
					state_reg == ST_HELD, dir_reg, flags_reg, drive_reg};
				`ADDR_REMAIN: prdata_reg <= 32'(remain_reg);
				default: prdata_reg <= 32'h0;
			endcase
		end
	end
	assign o_prdata = prdata_reg;

	// stop inputs
	assign pins_n = {i_decel_stop_in_n, i_limit_switch_in_n, i_servo_alarm_in_n, i_emergency_stop_in_n};
	always_comb
	begin
		unique case (ctrl_reg[`CTRL_FILTER_SEL_LO +: 2])
			2'h0: tc_sel = TC0;
			2'h1: tc_sel = TC1;
			2'h2: tc_sel = TC2;
			default: tc_sel = TC3;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++)
		begin : g_filt
			axis_input_filter #(
				.CNT_W(FILT_W)
			) u_filt (
				.i_mclk(i_mclk),
				.i_chip_reset_low(i_chip_reset_low),
				.i_pin_n(pins_n[gi]),
				.i_filter_en(ctrl_reg[`CTRL_FILTER_EN]),
				.i_limit(tc_sel),
				.o_active(act[gi])
			);
		end
	endgenerate

	// limit in the moving direction only; bit 2 plus, bit 3 minus
	assign inst_in = act[0] || act[1] ||
		(ctrl_reg[`CTRL_LIMIT_INSTANT] && (dir_reg ? act[3] : act[2]));
	assign decel_in = (|act[6:4]) ||
		(!ctrl_reg[`CTRL_LIMIT_INSTANT] && (dir_reg ? act[3] : act[2]));

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			inst_req_reg <= 1'b0;
			decel_req_reg <= 1'b0;
		end
		// a command refused while busy must not undo a pending stop
		else if (drive_cmd && state_reg == ST_IDLE)
		begin
			inst_req_reg <= 1'b0;
			decel_req_reg <= 1'b0;
		end
		else
		begin
			if (inst_cmd || inst_in)
				inst_req_reg <= 1'b1;
			if (decel_cmd || decel_in)
				decel_req_reg <= 1'b1;
		end
	end

	// sticky causes, write one to clear; a new event wins
	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			inst_seen_reg <= 1'b0;
			decel_seen_reg <= 1'b0;
		end
		else
		begin
			if (inst_req_reg && drive_reg)
				inst_seen_reg <= 1'b1;
			else if (wr && i_paddr == `ADDR_STATUS && i_pwdata[`ST_INSTANT_SEEN])
				inst_seen_reg <= 1'b0;
			if (decel_req_reg && drive_reg)
				decel_seen_reg <= 1'b1;
			else if (wr && i_paddr == `ADDR_STATUS && i_pwdata[`ST_DECEL_SEEN])
				decel_seen_reg <= 1'b0;
		end
	end

	// pulse timing; high half of the period, never below one clock
	assign hi_len = (per_reg[PER_W-1:1] == '0) ? PER_W'(1) : {1'b0, per_reg[PER_W-1:1]};
	assign end_high = (state_reg == ST_HIGH) && (tcnt_reg == '0);
	assign end_low = (state_reg == ST_LOW) && (tcnt_reg == '0);
	assign go_on = !inst_req_reg && (cont_reg || remain_reg != '0) &&
		!(decel_req_reg && phase_reg == PH_DECEL && per_reg >= start_per_reg);
	assign pulse_start = ((state_reg == ST_START) && (tcnt_reg != '0)) || (end_low && go_on);
	assign pulse_next = pulse_start || (pulse_reg && !end_high);
	assign per_up = {1'b0, per_reg} + {1'b0, accel_reg};

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			state_reg <= ST_IDLE;
			tcnt_reg <= '0;
			drive_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					// drive-active one clock after the write
					if (drive_cmd)
					begin
						drive_reg <= 1'b1;
						tcnt_reg <= '0;
						state_reg <= ctrl_reg[`CTRL_HOLD] ? ST_HELD : ST_START;
					end
				end
				ST_HELD:
				begin
					if (start_cmd)
					begin
						tcnt_reg <= PER_W'(1);
						state_reg <= ST_START;
					end
					else if (inst_req_reg)
						state_reg <= ST_DONE;
				end
				ST_START:
				begin
					// pulse two clocks after drive-active
					if (tcnt_reg == '0)
						tcnt_reg <= PER_W'(1);
					else
					begin
						tcnt_reg <= hi_len - PER_W'(1);
						state_reg <= ST_HIGH;
					end
				end
				ST_HIGH:
				begin
					if (end_high)
					begin
						tcnt_reg <= per_reg - hi_len - PER_W'(1);
						state_reg <= ST_LOW;
					end
					else
						tcnt_reg <= tcnt_reg - PER_W'(1);
				end
				ST_LOW:
				begin
					if (end_low && go_on)
					begin
						tcnt_reg <= hi_len - PER_W'(1);
						state_reg <= ST_HIGH;
					end
					else if (end_low)
						state_reg <= ST_DONE;
					else
						tcnt_reg <= tcnt_reg - PER_W'(1);
				end
				ST_DONE:
				begin
					drive_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// command capture and speed profile
	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			cont_reg <= 1'b0;
			interp_reg <= 1'b0;
			dir_cmd_reg <= 1'b0;
			remain_reg <= '0;
			accel_cnt_reg <= '0;
			per_reg <= `START_PER_RESET;
			phase_reg <= PH_ACCEL;
		end
		else if (drive_cmd && state_reg == ST_IDLE)
		begin
			cont_reg <= (wcmd == CMD_CONT_PLUS) || (wcmd == CMD_CONT_MINUS);
			interp_reg <= (wcmd == CMD_INTERP_PLUS) || (wcmd == CMD_INTERP_MINUS);
			dir_cmd_reg <= (wcmd == CMD_FIXED_MINUS) || (wcmd == CMD_CONT_MINUS) ||
				(wcmd == CMD_INTERP_MINUS);
			remain_reg <= count_reg;
			accel_cnt_reg <= '0;
			// interpolation runs at drive speed with no ramp
			per_reg <= (wcmd >= CMD_INTERP_PLUS) ? drive_per_reg : start_per_reg;
			phase_reg <= (wcmd >= CMD_INTERP_PLUS) ? PH_CONST : PH_ACCEL;
		end
		else
		begin
			// no wrap at zero, so a count of 0 still gives one pulse
			if (pulse_start && !cont_reg && remain_reg != '0)
				remain_reg <= remain_reg - CNT_W'(1);
			if (end_low && go_on && !interp_reg)
			begin
				if (decel_req_reg || (!cont_reg && remain_reg <= accel_cnt_reg))
				begin
					phase_reg <= PH_DECEL;
					per_reg <= (per_up > {1'b0, start_per_reg}) ? start_per_reg : per_up[PER_W-1:0];
				end
				else if ({1'b0, per_reg} > {1'b0, drive_per_reg} + {1'b0, accel_reg})
				begin
					per_reg <= per_reg - accel_reg;
					accel_cnt_reg <= accel_cnt_reg + CNT_W'(1);
				end
				else
				begin
					per_reg <= drive_per_reg;
					phase_reg <= PH_CONST;
				end
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
			dir_reg <= 1'b0;
		else if (drive_reg && (state_reg == ST_HELD || (state_reg == ST_START && tcnt_reg == '0)))
			dir_reg <= dir_cmd_reg;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			pulse_reg <= 1'b0;
			plus_reg <= 1'b0;
			minus_reg <= 1'b0;
			step_reg <= 1'b0;
		end
		else
		begin
			pulse_reg <= pulse_next;
			plus_reg <= pulse_next && !ctrl_reg[`CTRL_ONE_PULSE] && !dir_cmd_reg;
			minus_reg <= pulse_next && !ctrl_reg[`CTRL_ONE_PULSE] && dir_cmd_reg;
			step_reg <= pulse_next && ctrl_reg[`CTRL_ONE_PULSE];
		end
	end

	// lead split pulse one clock wider
	// split follows the pulse by one clock
	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			split_reg <= 1'b0;
			first_reg <= 1'b0;
		end
		else
		begin
			if (drive_cmd && state_reg == ST_IDLE)
				first_reg <= 1'b1;
			else if (pulse_start)
				first_reg <= 1'b0;
			split_reg <= ctrl_reg[`CTRL_SPLIT_EN] &&
				(pulse_reg || (pulse_start && first_reg && ctrl_reg[`CTRL_SPLIT_LEAD]));
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
		begin
			age_reg <= 2'h0;
			flags_reg <= 3'h0;
		end
		else
		begin
			if (!drive_reg)
				age_reg <= 2'h0;
			else if (age_reg != 2'h3)
				age_reg <= age_reg + 2'h1;
			if (drive_reg && age_reg >= 2'h2)
				flags_reg <= {phase_reg == PH_DECEL, phase_reg == PH_CONST, phase_reg == PH_ACCEL};
			else
				flags_reg <= 3'h0;
		end
	end

	// all outputs reset at the first edge
	assign o_axis_drive_active = drive_reg;
	assign o_plus_pulse_out = plus_reg;
	assign o_minus_pulse_out = minus_reg;
	assign o_step_pulse_out = step_reg;
	assign o_direction_out = dir_reg;
	assign o_split_pulse_out = split_reg;
	assign o_accel_phase_flag = flags_reg[0];
	assign o_const_speed_flag = flags_reg[1];
	assign o_decel_phase_flag = flags_reg[2];
endmodule // axis_pulse_drive_timing
`default_nettype wire

// ===== testbench/axis_drive_asserts.sv
// checker for the axis pulse-drive block, watching only its ports
// assumes one clock and that control bits are seen on the bus
`timescale 1ns/1ps
`default_nettype none
`include "axis_drive_defines.svh"
module axis_drive_asserts
	import axis_drive_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_chip_reset_low,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_axis_drive_active,
	input wire logic o_plus_pulse_out,
	input wire logic o_minus_pulse_out,
	input wire logic o_step_pulse_out,
	input wire logic o_direction_out,
	input wire logic o_split_pulse_out,
	input wire logic o_accel_phase_flag,
	input wire logic o_const_speed_flag,
	input wire logic o_decel_phase_flag
);
	logic [3:0] ctrl_reg;
	wire logic wr = i_psel && i_penable && o_pready && i_pwrite;
	wire logic cmd_wr = wr && i_paddr == `ADDR_CMD;
	wire logic drv = o_axis_drive_active;
	wire logic go = cmd_wr && !drv && i_pwdata[3:0] inside {[CMD_FIXED_PLUS:CMD_INTERP_MINUS]};
	wire logic pls = o_plus_pulse_out || o_minus_pulse_out || o_step_pulse_out;
	wire logic flg = o_accel_phase_flag || o_const_speed_flag || o_decel_phase_flag;
	wire logic hold = ctrl_reg[`CTRL_HOLD];
	wire logic spl = ctrl_reg[`CTRL_SPLIT_EN];
	// snooped copy, so mode-dependent timing is judged by the mode in force
	always_ff @(posedge i_mclk)
	begin
		if (!i_chip_reset_low)
			ctrl_reg <= 4'h0;
		else if (wr && i_paddr == `ADDR_CTRL)
			ctrl_reg <= i_pwdata[3:0];
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_chip_reset_low);
	sequence step_late_s;
		##1 !o_step_pulse_out ##1 o_step_pulse_out;
	endsequence
	// reset itself is the cause here, so it cannot also disable the check
	rst_outputs_a: assert property (disable iff (1'b0) !i_chip_reset_low |=> !o_pready && !drv && !pls && !flg && !o_split_pulse_out)
		else $error("outputs not cleared in reset");
	guard_window_a: assert property ($rose(i_chip_reset_low) |-> !o_pready [*4] ##1 o_pready)
		else $error("bus guard window wrong");
	drive_rise_a: assert property (go |=> drv)
		else $error("drive active late");
	first_pulse_a: assert property (go && !hold |-> ##[1:4] pls)
		else $error("first pulse late");
	hold_release_a: assert property (cmd_wr && i_pwdata[3:0] == CMD_START_HELD && drv |-> ##[1:4] pls)
		else $error("held axis did not start");
	idle_quiet_a: assert property (!drv |-> !pls)
		else $error("pulse while idle");
	flags_rise_a: assert property ($rose(drv) && !hold |-> !flg [*3] ##1 flg)
		else $error("phase flags timing");
	flags_fall_a: assert property ($fell(drv) |-> flg ##1 !flg)
		else $error("phase flags not cleared");
	step_start_a: assert property ($rose(drv) && ctrl_reg[`CTRL_ONE_PULSE] && !hold |-> step_late_s)
		else $error("step pulse start timing");
	dir_around_a: assert property (o_step_pulse_out |-> $stable(o_direction_out) ##1 $stable(o_direction_out))
		else $error("direction moved near pulse");
	split_lead_a: assert property ($rose(drv) && spl && ctrl_reg[`CTRL_SPLIT_LEAD] && !hold |-> ##2 pls && o_split_pulse_out)
		else $error("lead split not aligned");
	split_lag_a: assert property (spl && !ctrl_reg[`CTRL_SPLIT_LEAD] && $rose(pls) |-> !o_split_pulse_out ##1 o_split_pulse_out)
		else $error("split pulse not delayed");
endmodule // axis_drive_asserts
bind axis_pulse_drive_timing axis_drive_asserts axis_drive_asserts_inst (.i_mclk, .i_chip_reset_low, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_axis_drive_active, .o_plus_pulse_out, .o_minus_pulse_out,
	.o_step_pulse_out, .o_direction_out, .o_split_pulse_out, .o_accel_phase_flag, .o_const_speed_flag,
	.o_decel_phase_flag);
`default_nettype wire

// ===== testbench/motor_drive_model.sv
// motor driver model: counts steps each way, raises its alarm on request
// assumes active-high pulses and the axis clock
`timescale 1ns/1ps
`default_nettype none
module motor_drive_model (
	input wire logic i_mclk,
	input wire logic i_plus,
	input wire logic i_minus,
	input wire logic i_step,
	input wire logic i_dir,
	input wire logic i_fault,
	output logic o_alarm_n = 1'b1,
	output int o_fwd = 0,
	output int o_rev = 0
);
	logic p_reg = 1'b0;
	logic m_reg = 1'b0;
	logic s_reg = 1'b0;
	logic f_reg = 1'b0;
	always @(posedge i_mclk)
	begin
		if (i_plus && !p_reg || i_step && !s_reg && !i_dir)
			o_fwd <= o_fwd + 1;
		if (i_minus && !m_reg || i_step && !s_reg && i_dir)
			o_rev <= o_rev + 1;
		p_reg <= i_plus;
		m_reg <= i_minus;
		s_reg <= i_step;
	end
	always @(posedge i_mclk)
	begin
		f_reg <= i_fault;
		o_alarm_n <= !(i_fault || f_reg);
	end
endmodule // motor_drive_model
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the axis pulse-drive block
// assumes the bound checker and a motor driver model on the pulse pins
`timescale 1ns/1ps
`default_nettype none
`include "axis_drive_defines.svh"
module tb_top;
	import axis_drive_pkg::*;
	logic i_mclk = 1'b0;
	logic i_chip_reset_low = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0;
	logic [2:0] i_decel_stop_in_n = 3'h7;
	logic fault = 1'b0;
	logic emg_n = 1'b1;
	logic [1:0] lim_n = 2'h3;
	logic i_servo_alarm_in_n, o_pready, o_pslverr, o_axis_drive_active, o_plus_pulse_out, o_minus_pulse_out;
	logic o_step_pulse_out, o_direction_out, o_split_pulse_out, o_accel_phase_flag, o_const_speed_flag;
	logic o_decel_phase_flag, err;
	logic [31:0] o_prdata, rd;
	int fwd, rev;
	int mismatches = 0;
	int check_count = 0;
	initial forever #50 i_mclk = ~i_mclk;
	// stop pins driven by the bench; the alarm comes from the motor model
	axis_pulse_drive_timing axis_pulse_drive_timing_inst (.i_mclk, .i_chip_reset_low, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_emergency_stop_in_n(emg_n), .i_servo_alarm_in_n,
		.i_limit_switch_in_n(lim_n), .i_decel_stop_in_n, .o_axis_drive_active, .o_plus_pulse_out, .o_minus_pulse_out,
		.o_step_pulse_out, .o_direction_out, .o_split_pulse_out, .o_accel_phase_flag, .o_const_speed_flag,
		.o_decel_phase_flag);
	motor_drive_model motor_drive_model_inst (.i_mclk(i_mclk), .i_plus(o_plus_pulse_out), .i_minus(o_minus_pulse_out),
		.i_step(o_step_pulse_out), .i_dir(o_direction_out), .i_fault(fault), .o_alarm_n(i_servo_alarm_in_n),
		.o_fwd(fwd), .o_rev(rev));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		@(posedge i_mclk);
		while (o_pready !== 1'b1)
			@(posedge i_mclk);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic cmd(input cmd_t c);
		apb(1'b1, `ADDR_CMD, {28'h0, c});
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		@(posedge i_mclk);
		while (o_axis_drive_active !== 1'b0 && n < 3000)
		begin
			@(posedge i_mclk);
			n++;
		end
		chk("drive idle", 32'h0, o_axis_drive_active);
	endtask
	task automatic t_reset();
		i_chip_reset_low <= 1'b0;
		repeat (8) @(posedge i_mclk);
		chk("drive in reset", 32'h0, o_axis_drive_active);
		i_chip_reset_low <= 1'b1;
		// bus left alone while the guard runs
		repeat (4) @(posedge i_mclk);
		apb(1'b0, `ADDR_START_PER, 32'h0);
		chk("start period", `START_PER_RESET, rd);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped error", 32'h1, err);
		// short periods keep the whole run brief
		apb(1'b1, `ADDR_START_PER, 32'h8);
		apb(1'b1, `ADDR_DRIVE_PER, 32'h4);
		$display("test reset done");
	endtask
	task automatic t_drive(input logic [7:0] ctl, input cmd_t c, input int n, input logic d);
		int f0, r0;
		logic cont;
		cont = (c == CMD_CONT_PLUS) || (c == CMD_CONT_MINUS);
		apb(1'b1, `ADDR_CTRL, {24'h0, ctl});
		apb(1'b1, `ADDR_COUNT, n);
		f0 = fwd;
		r0 = rev;
		cmd(c);
		// continuous never ends by itself; n is then a lower bound
		if (cont)
		begin
			repeat (40) @(posedge i_mclk);
			cmd(CMD_DECEL_STOP);
		end
		wait_idle();
		if (cont)
		begin
			chk("pulses run", 32'h1, (d ? rev - r0 : fwd - f0) >= n);
			chk("pulses other way", 32'h0, d ? fwd - f0 : rev - r0);
		end
		else
		begin
			chk("forward pulses", d ? 0 : n, fwd - f0);
			chk("reverse pulses", d ? n : 0, rev - r0);
		end
		repeat (6) @(posedge i_mclk);
		chk("direction held", d, o_direction_out);
		$display("test drive %0d done", c);
	endtask
	task automatic t_hold();
		int f0;
		apb(1'b1, `ADDR_CTRL, 32'h2);
		f0 = fwd;
		cmd(CMD_CONT_PLUS);
		repeat (20) @(posedge i_mclk);
		chk("held pulses", f0, fwd);
		cmd(CMD_START_HELD);
		repeat (30) @(posedge i_mclk);
		chk("released", 32'h1, fwd > f0);
		cmd(CMD_INSTANT_STOP);
		wait_idle();
		f0 = fwd;
		repeat (20) @(posedge i_mclk);
		chk("after stop", f0, fwd);
		$display("test hold done");
	endtask
	task automatic t_inputs();
		// earlier stops left their causes set
		apb(1'b1, `ADDR_STATUS, 32'hC0);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk("seen cleared", 32'h0, rd[7:6]);
		apb(1'b1, `ADDR_CTRL, 32'h0);
		cmd(CMD_CONT_MINUS);
		repeat (20) @(posedge i_mclk);
		fault <= 1'b1;
		@(posedge i_mclk);
		fault <= 1'b0;
		wait_idle();
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk("instant seen", 32'h1, rd[`ST_INSTANT_SEEN]);
		apb(1'b1, `ADDR_STATUS, 32'hC0);
		cmd(CMD_CONT_PLUS);
		repeat (30) @(posedge i_mclk);
		i_decel_stop_in_n <= 3'h6;
		repeat (3) @(posedge i_mclk);
		i_decel_stop_in_n <= 3'h7;
		wait_idle();
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk("decel seen", 32'h1, rd[`ST_DECEL_SEEN]);
		// filter on, shortest constant, limit stops at once
		apb(1'b1, `ADDR_CTRL, 32'h30);
		cmd(CMD_CONT_PLUS);
		repeat (20) @(posedge i_mclk);
		// two clocks wide, still shorter than the filter
		emg_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		emg_n <= 1'b1;
		repeat (20) @(posedge i_mclk);
		chk("glitch filtered", 32'h1, o_axis_drive_active);
		lim_n <= 2'h2;
		wait_idle();
		lim_n <= 2'h3;
		apb(1'b0, `ADDR_STATUS, 32'h0);
		chk("limit instant", 32'h1, rd[`ST_INSTANT_SEEN]);
		$display("test inputs done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		t_reset();
		t_drive(8'h01, CMD_FIXED_PLUS, 3, 1'b0);
		t_drive(8'h00, CMD_FIXED_MINUS, 2, 1'b1);
		t_drive(8'h0D, CMD_INTERP_PLUS, 2, 1'b0);
		t_drive(8'h04, CMD_INTERP_MINUS, 4, 1'b1);
		t_drive(8'h01, CMD_CONT_MINUS, 4, 1'b1);
		t_hold();
		t_inputs();
		cmd(CMD_CONT_PLUS);
		repeat (10) @(posedge i_mclk);
		t_reset();
		stop_test();
	end
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		mismatches++;
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
